// ### dv/ppm_board_model.sv
// Board-side model of whatever sits on the general-purpose port pins.
// Assumes the pin port block drives with pin/enable pairs and one clock.
`timescale 1ns/1ns
module ppm_board_model
	import ppm_pkg::*;
(
	input  wire logic                     ref_clk_i,   // System clock
	input  wire logic [ppm_pkg::GP_W-1:0] gp_pin_o,    // Device drive values
	input  wire logic [ppm_pkg::GP_W-1:0] gp_oe_o,     // Device drive enables
	input  wire logic [ppm_pkg::GP_W-1:0] gp_pu_o,     // Device pull-ups on
	input  wire logic [ppm_pkg::GP_W-1:0] board_en_i,  // Board drives the line
	input  wire logic [ppm_pkg::GP_W-1:0] board_val_i, // Board drive values
	output logic      [ppm_pkg::GP_W-1:0] gp_wire_o    // Resolved line levels
);
	// ==========================================================
	// Floating-line pattern
	logic                  flip_reg = 1'b0;
	logic [GP_W-1:0]       float_lv;

	// Undriven lines without a pull-up change every cycle so no stale value passes
	always_ff @(posedge ref_clk_i) begin
		flip_reg <= ~flip_reg;
	end
	assign float_lv = {17{flip_reg, ~flip_reg}};

	// ==========================================================
	// Line resolution: device, then board, then pull-up or float
	assign gp_wire_o = (gp_oe_o & gp_pin_o)
		| (~gp_oe_o & board_en_i & board_val_i)
		| (~gp_oe_o & ~board_en_i & (gp_pu_o | float_lv));
endmodule : ppm_board_model

// ### dv/ppm_port_tb.sv
// Self-checking bench for the pin port and memory map block.
// Assumes the small-segment, sixteen-kilobyte build with a board model on the pins.
`timescale 1ns/1ns
module ppm_port_tb;
	import ppm_pkg::*;
	localparam logic [3:0] P5_OPT = 4'hA;
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [GP_W-1:0] latch = GP_ZERO, dir = GP_DIR_RST, puen = GP_ZERO;
	logic [GP_W-1:0] bval = GP_ZERO, ben = GP_DIR_RST;
	logic [GP_W-1:0] wire_lv, pin_o, oe_o, pu_o, rd_o;
	logic [5:0] p6 = 6'h00, p6_rd, alt_en = 6'h00, alt_val = 6'h00;
	logic ser_en = 1'b0, master = 1'b0, sck_out = 1'b0, sck_in, ssel, sin, cpt;
	logic [7:0] irq_mode = 8'h00;
	logic [3:0] irq, kr_en = 4'h0, com_d = 4'h0, com;
	logic kr_irq, tb_en = 1'b0, tb_cnt, rom_hit, disp_hit;
	logic [14:0] seg_d = 15'h0000, seg;
	logic [15:0] addr = 16'h0000;
	logic [15:0] addr_tbl [10] = '{16'h0000, 16'h2FFF, 16'h3FFF, 16'h4000, 16'hF9FF,
		16'hFA00, 16'hFA04, 16'hFA05, 16'hFA0E, 16'hFFFF};
	int errors = 0, total_checks = 0, n_kr, n_tb;
	int n_irq [4];

	always #4 ref_clk_i = ~ref_clk_i;

	// ==========================================================
	// Design and board
	ppm_port #(.SMALL_SEG(1'b1), .ROM_16K(1'b1), .P5_PULLUP(P5_OPT)) ppm_port_inst (
		.ref_clk_i(ref_clk_i), .rst_i(rst_i), .gp_latch_i(latch), .gp_dir_i(dir),
		.gp_puen_i(puen), .gp_pin_i(wire_lv), .gp_pin_o(pin_o), .gp_oe_o(oe_o),
		.gp_pu_o(pu_o), .gp_rd_o(rd_o), .p6_pin_i(p6), .p6_rd_o(p6_rd),
		.alt_en_i(alt_en), .alt_val_i(alt_val), .ser_en_i(ser_en),
		.sck_master_i(master), .sck_out_i(sck_out), .sck_in_o(sck_in),
		.ssel_in_o(ssel), .sin_o(sin), .cpt_o(cpt), .irq_mode_i(irq_mode),
		.ext_irq_o(irq), .kr_en_i(kr_en), .kr_irq_o(kr_irq), .tb_cnt_en_i(tb_en),
		.tb_count_o(tb_cnt), .seg_data_i(seg_d), .com_data_i(com_d), .seg_o(seg),
		.com_o(com), .addr_i(addr), .rom_hit_o(rom_hit), .disp_hit_o(disp_hit));
	ppm_board_model ppm_board_model_inst (
		.ref_clk_i(ref_clk_i), .gp_pin_o(pin_o), .gp_oe_o(oe_o), .gp_pu_o(pu_o),
		.board_en_i(ben), .board_val_i(bval), .gp_wire_o(wire_lv));

	// ==========================================================
	// Expectation functions
	function automatic logic [GP_W-1:0] f_oe();
		logic [GP_W-1:0] o;
		o = ~dir;
		if (ser_en) o[BIT_SCK] = master;
		return o;
	endfunction : f_oe

	function automatic logic [GP_W-1:0] f_pin(input logic [GP_W-1:0] oe);
		logic [GP_W-1:0] v;
		int alt_bit [6] = '{BIT_BUZ, BIT_SOUT, BIT_WTO, BIT_TAO, BIT_TB0, BIT_TB1};
		v = latch;
		for (int i = 0; i < ALT_W; i++) if (alt_en[i]) v[alt_bit[i]] = alt_val[i];
		if (ser_en && master) v[BIT_SCK] = sck_out;
		return v & oe;
	endfunction : f_pin

	function automatic logic [GP_W-1:0] f_pu(input logic [GP_W-1:0] oe);
		logic [GP_W-1:0] p;
		p = puen;
		p[P5_LSB +: P5_W] = P5_OPT;
		return p & ~oe;
	endfunction : f_pu

	// ==========================================================
	// Comparison, closing and watchdog
	task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
		end
	endtask : check

	task automatic end_of_test();
		if (errors == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : end_of_test

	initial begin
		#(8 * 20000);
		errors++;
		end_of_test();
	end

	// ==========================================================
	// Stimulus helpers
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask : tick

	// Random pin configuration, then settled outputs compared
	task automatic rand_step();
		logic [GP_W-1:0] oe, pv, pu, w;
		tick(1);
		latch = GP_W'({$urandom, $urandom});
		dir = GP_W'({$urandom, $urandom});
		puen = GP_W'({$urandom, $urandom});
		alt_en = 6'($urandom);
		alt_val = 6'($urandom);
		{ser_en, master, sck_out} = 3'($urandom);
		if (ser_en && master) puen[BIT_SCK] = 1'b0;
		p6 = 6'($urandom);
		seg_d = 15'($urandom);
		com_d = 4'($urandom);
		oe = f_oe();
		pu = f_pu(oe);
		pv = f_pin(oe);
		ben = GP_W'({$urandom, $urandom}) | ~pu;
		bval = GP_W'({$urandom, $urandom});
		w = (oe & pv) | (~oe & ben & bval) | (~oe & ~ben & pu);
		tick(5);
		check("gp_oe", oe_o, oe);
		check("gp_pin", pin_o, pv);
		check("gp_pu", pu_o, pu);
		check("gp_rd", rd_o, (dir & w) | (~dir & latch));
		check("p6_rd", p6_rd, p6);
		check("sck_in", sck_in, w[BIT_SCK]);
		check("ser_in", {ssel, sin, cpt}, {w[BIT_SSEL], w[BIT_SIN], w[BIT_CPT]});
		check("seg", seg, seg_d & SEG_MASK_SMALL);
		check("com", com, com_d);
	endtask : rand_step

	// One board edge, then event pulses counted over eight cycles
	task automatic edge_to(input int b, input logic v);
		n_irq = '{default: 0};
		n_kr = 0;
		n_tb = 0;
		tick(1);
		bval[b] = v;
		repeat (8) begin
			tick(1);
			for (int i = 0; i < IRQ_N; i++) if (irq[i] === 1'b1) n_irq[i]++;
			if (kr_irq === 1'b1) n_kr++;
			if (tb_cnt === 1'b1) n_tb++;
		end
	endtask : edge_to

	// ==========================================================
	// Main sequence
	initial begin
		void'($urandom(32'h2cb07193));
		latch = GP_DIR_RST;
		dir = GP_ZERO;
		seg_d = 15'h7FFF;
		alt_en = 6'h3F;
		tick(10);
		check("rst_oe", oe_o, GP_ZERO);
		check("rst_pin", pin_o, GP_ZERO);
		check("rst_seg", seg, 64'h0);
		rst_i = 1'b0;
		dir = GP_DIR_RST;
		alt_en = 6'h00;
		tick(1);
		check("rel_oe", oe_o, GP_ZERO);
		for (int n = 0; n < 150; n++) rand_step();
		// Mid-run reset with pins held high and rising edges armed
		rst_i = 1'b1;
		dir = GP_DIR_RST;
		ben = GP_DIR_RST;
		bval = GP_DIR_RST;
		irq_mode = 8'h55;
		tb_en = 1'b1;
		tick(4);
		check("mid_oe", oe_o, GP_ZERO);
		check("mid_pu", pu_o, GP_ZERO);
		rst_i = 1'b0;
		edge_to(BIT_IRQ0, 1'b1);
		check("rst_evt", 64'(n_irq[0] + n_irq[1] + n_irq[2] + n_irq[3] + n_tb), 64'h0);
		irq_mode = 8'h00;
		tb_en = 1'b0;
		// Memory map corners then random addresses
		for (int n = 0; n < 40; n++) begin
			addr = (n < 10) ? addr_tbl[n] : 16'($urandom);
			tick(2);
			check("rom_hit", rom_hit, addr <= ROM_LAST_16K);
			check("disp_hit", disp_hit, addr >= DISP_RAM_BASE && addr <= DISP_LAST_SMALL);
		end
		// Edge events on all inputs, all modes
		dir = GP_DIR_RST;
		ben = GP_DIR_RST;
		bval = GP_ZERO;
		ser_en = 1'b0;
		tick(6);
		for (int i = 0; i < IRQ_N; i++) begin
			for (int m = 0; m < 4; m++) begin
				irq_mode = 8'(m << (2 * i));
				tb_en = (i == 1);
				edge_to(BIT_IRQ0 + i, 1'b1);
				check("irq_rise", 64'(n_irq[i]), 64'(m & 1));
				if (i == 1) check("tb_rise", 64'(n_tb), 64'h1);
				if (i == 0) check("cpt", cpt, 64'h1);
				edge_to(BIT_IRQ0 + i, 1'b0);
				check("irq_fall", 64'(n_irq[i]), 64'((m >> 1) & 1));
				if (i == 1) check("tb_fall", 64'(n_tb), 64'h0);
			end
		end
		irq_mode = 8'h00;
		tb_en = 1'b0;
		for (int k = 0; k < KR_N; k++) begin
			for (int e = 0; e < 2; e++) begin
				kr_en = 4'(e << k);
				edge_to(k, 1'b1);
				check("kr_rise", 64'(n_kr), 64'h0);
				edge_to(k, 1'b0);
				check("kr_fall", 64'(n_kr), 64'(e));
			end
		end
		end_of_test();
	end
endmodule : ppm_port_tb

// ### verilog/ppm_pkg.sv
// Shared constants and types for the pin port and memory map block.
// Assumes a single 125 MHz clock domain and no register bus.
package ppm_pkg;

	// ==========================================================
	// Flat vector of all bidirectional port bits
	localparam int GP_W   = 34;
	localparam int P0_LSB = 0;
	localparam int P0_W   = 4;
	localparam int P1_LSB = 4;
	localparam int P1_W   = 2;
	localparam int P2_LSB = 6;
	localparam int P2_W   = 7;
	localparam int P3_LSB = 13;
	localparam int P3_W   = 4;
	localparam int P5_LSB = 17;
	localparam int P5_W   = 4;
	localparam int P7_LSB = 21;
	localparam int P7_W   = 3;
	localparam int P8_LSB = 24;
	localparam int P8_W   = 2;
	localparam int P9_LSB = 26;
	localparam int P9_W   = 8;
	localparam int P6_W   = 6;

	// ==========================================================
	// Shared-function bit positions inside the flat vector
	localparam int BIT_BUZ  = 7;
	localparam int BIT_SSEL = 8;
	localparam int BIT_SCK  = 9;
	localparam int BIT_SOUT = 10;
	localparam int BIT_SIN  = 11;
	localparam int BIT_WTO  = 12;
	localparam int BIT_IRQ0 = 13;
	localparam int BIT_CPT  = 13;
	localparam int BIT_TBIN = 14;
	localparam int BIT_TAO  = 14;
	localparam int BIT_TB0  = 15;
	localparam int BIT_TB1  = 16;
	localparam int ALT_W    = 6;
	localparam int IRQ_N    = 4;
	localparam int KR_N     = 4;

	// ==========================================================
	// Masks and reset values
	localparam logic [GP_W-1:0] P89_MASK   = 34'h3_FF00_0000;
	localparam logic [GP_W-1:0] P5_MASK    = 34'h0_001E_0000;
	localparam logic [GP_W-1:0] GP_DIR_RST = 34'h3_FFFF_FFFF;
	localparam logic [GP_W-1:0] GP_ZERO    = 34'h0_0000_0000;
	localparam logic [3:0]      P5_PU_DEF  = 4'h0;

	// ==========================================================
	// Display and memory map
	localparam int          SEG_SMALL       = 5;
	localparam int          SEG_LARGE       = 15;
	localparam int          COM_W           = 4;
	localparam int          ADDR_W          = 16;
	localparam logic [14:0] SEG_MASK_SMALL  = 15'h001F;
	localparam logic [14:0] SEG_MASK_LARGE  = 15'h7FFF;
	localparam logic [15:0] DISP_RAM_BASE   = 16'hFA00;
	localparam logic [15:0] DISP_LAST_SMALL = 16'hFA04;
	localparam logic [15:0] DISP_LAST_LARGE = 16'hFA0E;
	localparam logic [15:0] ROM_LAST_12K    = 16'h2FFF;
	localparam logic [15:0] ROM_LAST_16K    = 16'h3FFF;

	// Valid-edge selection of an external interrupt input
	typedef enum logic [1:0] {
		PPM_EDGE_OFF  = 2'h0,
		PPM_EDGE_RISE = 2'h1,
		PPM_EDGE_FALL = 2'h2,
		PPM_EDGE_BOTH = 2'h3
	} ppm_edge_t;

endpackage : ppm_pkg

// ### verilog/ppm_port.sv
// Port pin logic: direction, pull-ups, shared functions, edge detection,
// segment drivers and memory map range decoding.
// Assumes control bits come from CPU-side logic on the same clock.
//
// How it works
// - Port zero has four bits, each direction set alone; also key-return inputs.
// - Port one has two bidirectional bits with separate directions, no shared use.
// - Port two has seven bits shared with buzzer, serial and wide timer.
// - Port three has four bits shared with interrupts, capture and timer pins.
// - Port five pull-ups come from a build option, not software.
// - Port six is six input bits, never driven.
// - Port seven has three bidirectional bits with per-bit direction.
// - Small-segment build adds port eight, two bidirectional bits.
// - Small-segment build adds port nine, eight bidirectional bits.
// - Software pull-up applies only when enabled and the bit is an input.
// - Each interrupt input detects rising, falling or both edges as selected.
// - Falling edges on enabled key-return inputs raise a key event.
// - Serial clock pin drives when serial master, is an input when serial slave, else follows direction.
// - Timer count input pulses on rising edges of its shared pin.
// - Segment outputs are driven from reset; five or fifteen per build.
// - Display memory ends at FA04 or FA0E depending on build.
// - Program memory ends at 2FFF or 3FFF depending on size.
`timescale 1ns/1ns
module ppm_port
	import ppm_pkg::*;
#(
	parameter bit         SMALL_SEG  = 1'b1,      // Five segments, ports 8 and 9
	parameter bit         ROM_16K    = 1'b1,      // Sixteen-kilobyte program memory
	parameter logic [3:0] P5_PULLUP  = 4'h0       // Build-time port five pull-ups
) (
	input  wire logic                     ref_clk_i,    // 125 MHz clock
	input  wire logic                     rst_i,        // Synchronous reset
	input  wire logic [ppm_pkg::GP_W-1:0] gp_latch_i,   // Output latch values
	input  wire logic [ppm_pkg::GP_W-1:0] gp_dir_i,     // 1 = input, 0 = output
	input  wire logic [ppm_pkg::GP_W-1:0] gp_puen_i,    // Software pull-up enables
	input  wire logic [ppm_pkg::GP_W-1:0] gp_pin_i,     // Pin levels in
	output logic      [ppm_pkg::GP_W-1:0] gp_pin_o,     // Pin levels out
	output logic      [ppm_pkg::GP_W-1:0] gp_oe_o,      // Pin drive enables
	output logic      [ppm_pkg::GP_W-1:0] gp_pu_o,      // Pull-up enables
	output logic      [ppm_pkg::GP_W-1:0] gp_rd_o,      // Port read data
	input  wire logic [ppm_pkg::P6_W-1:0] p6_pin_i,     // Input-only pins
	output logic      [ppm_pkg::P6_W-1:0] p6_rd_o,      // Input-only read data
	input  wire logic [ppm_pkg::ALT_W-1:0] alt_en_i,    // Shared output enables
	input  wire logic [ppm_pkg::ALT_W-1:0] alt_val_i,   // Shared output values
	input  wire logic                     ser_en_i,     // Serial unit active
	input  wire logic                     sck_master_i, // Serial clock is output
	input  wire logic                     sck_out_i,    // Serial clock to drive
	output logic                          sck_in_o,     // Serial clock from pin
	output logic                          ssel_in_o,    // Serial select from pin
	output logic                          sin_o,        // Serial data from pin
	output logic                          cpt_o,        // Capture trigger level
	input  wire logic [7:0]               irq_mode_i,   // Two edge bits per input
	output logic      [ppm_pkg::IRQ_N-1:0] ext_irq_o,   // Edge event pulses
	input  wire logic [ppm_pkg::KR_N-1:0] kr_en_i,      // Key-return enables
	output logic                          kr_irq_o,     // Key-return pulse
	input  wire logic                     tb_cnt_en_i,  // Count input enabled
	output logic                          tb_count_o,   // Count pulse to timer
	input  wire logic [14:0]              seg_data_i,   // Segment drive values
	input  wire logic [ppm_pkg::COM_W-1:0] com_data_i,  // Common drive values
	output logic      [14:0]              seg_o,        // Segment outputs
	output logic      [ppm_pkg::COM_W-1:0] com_o,       // Common outputs
	input  wire logic [ppm_pkg::ADDR_W-1:0] addr_i,     // CPU address
	output logic                          rom_hit_o,    // Address in program memory
	output logic                          disp_hit_o    // Address in display memory
);

	import ppm_pkg::*;

	// ==========================================================
	// Edge classification shared by interrupt and count inputs
	function automatic logic ppm_edge_hit(input ppm_edge_t m, input logic cur,
		input logic prev);
		logic hit;
		hit = 1'b0;
		unique case (m)
			PPM_EDGE_OFF:  hit = 1'b0;
			PPM_EDGE_RISE: hit = cur & ~prev;
			PPM_EDGE_FALL: hit = ~cur & prev;
			PPM_EDGE_BOTH: hit = cur ^ prev;
		endcase
		return hit;
	endfunction : ppm_edge_hit

	// ==========================================================
	// Pin synchronisers
	logic [GP_W+P6_W-1:0] all_sync;
	logic [GP_W-1:0]      gp_cur;
	logic [P6_W-1:0]      p6_cur;

	ppm_sync2 #(.W(GP_W + P6_W)) u_sync (
		.ref_clk_i (ref_clk_i),
		.rst_i     (rst_i),
		.async_i   ({p6_pin_i, gp_pin_i}),
		.sync_o    (all_sync)
	);

	assign gp_cur = all_sync[GP_W-1:0];
	assign p6_cur = all_sync[GP_W+P6_W-1:GP_W];

	// ==========================================================
	// Present bits, shared outputs and serial clock steering
	logic [GP_W-1:0] present;
	logic [GP_W-1:0] alt_en_vec;
	logic [GP_W-1:0] alt_val_vec;
	logic [GP_W-1:0] sck_bit;
	logic            sck_drive;
	logic            sck_slave;

	assign present   = SMALL_SEG ? GP_DIR_RST : ~P89_MASK;
	assign sck_drive = ser_en_i & sck_master_i;
	assign sck_slave = ser_en_i & ~sck_master_i;
	assign sck_bit   = GP_ZERO | (34'h1 << BIT_SCK);

	// Shared outputs placed on their pins
	always_comb begin
		alt_en_vec           = GP_ZERO;
		alt_val_vec          = GP_ZERO;
		alt_en_vec[BIT_BUZ]  = alt_en_i[0];
		alt_val_vec[BIT_BUZ] = alt_val_i[0];
		alt_en_vec[BIT_SOUT] = alt_en_i[1];
		alt_val_vec[BIT_SOUT]= alt_val_i[1];
		alt_en_vec[BIT_WTO]  = alt_en_i[2];
		alt_val_vec[BIT_WTO] = alt_val_i[2];
		alt_en_vec[BIT_TAO]  = alt_en_i[3];
		alt_val_vec[BIT_TAO] = alt_val_i[3];
		alt_en_vec[BIT_TB0]  = alt_en_i[4];
		alt_val_vec[BIT_TB0] = alt_val_i[4];
		alt_en_vec[BIT_TB1]  = alt_en_i[5];
		alt_val_vec[BIT_TB1] = alt_val_i[5];
		alt_en_vec[BIT_SCK]  = sck_drive;
		alt_val_vec[BIT_SCK] = sck_out_i;
	end

	// ==========================================================
	// Next values for pin drive, pull-ups and read data
	logic [GP_W-1:0] oe_next;
	logic [GP_W-1:0] out_next;
	logic [GP_W-1:0] pu_sw;
	logic [GP_W-1:0] pu_fix;
	logic [GP_W-1:0] pu_next;
	logic [GP_W-1:0] rd_next;

	// Output bit drives unless it is a slave serial clock
	assign oe_next  = ((~gp_dir_i & present) & ~(sck_slave ? sck_bit : GP_ZERO))
		| (sck_drive ? sck_bit : GP_ZERO);
	assign out_next = ((alt_en_vec & alt_val_vec) | (~alt_en_vec & gp_latch_i))
		& oe_next;
	assign pu_sw    = gp_puen_i & ~P5_MASK;
	assign pu_fix   = GP_ZERO | ({30'h0, P5_PULLUP} << P5_LSB);
	assign pu_next  = (pu_sw | pu_fix) & ~oe_next & present;
	assign rd_next  = ((gp_dir_i & gp_cur) | (~gp_dir_i & gp_latch_i)) & present;

	// Drive and pull-up registers, all inputs after reset
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			gp_oe_o  <= GP_ZERO;
			gp_pin_o <= GP_ZERO;
			gp_pu_o  <= GP_ZERO;
			gp_rd_o  <= GP_ZERO;
			p6_rd_o  <= '0;
		end else begin
			gp_oe_o  <= oe_next;
			gp_pin_o <= out_next;
			gp_pu_o  <= pu_next;
			gp_rd_o  <= rd_next;
			p6_rd_o  <= p6_cur;
		end
	end

	// ==========================================================
	// Edge detection for interrupts, key return and count input
	logic [GP_W-1:0]  gp_prev_reg;
	logic [2:0]       fill_reg;
	logic             fill_done;
	logic [IRQ_N-1:0] irq_next;
	logic             kr_next;
	logic             tb_next;

	for (genvar i = 0; i < IRQ_N; i++) begin : g_irq
		assign irq_next[i] = ppm_edge_hit(ppm_edge_t'(irq_mode_i[2*i +: 2]),
			gp_cur[BIT_IRQ0+i], gp_prev_reg[BIT_IRQ0+i]);
	end

	assign kr_next = |(kr_en_i & gp_prev_reg[P0_LSB +: KR_N]
		& ~gp_cur[P0_LSB +: KR_N]);
	assign tb_next = tb_cnt_en_i & ppm_edge_hit(PPM_EDGE_RISE,
		gp_cur[BIT_TBIN], gp_prev_reg[BIT_TBIN]);

	// No events until sync stages and previous sample hold real pin levels,
	// so a pin idling high gives no false edge after reset
	assign fill_done = fill_reg[2];

	// Event pulses and shared input levels
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			gp_prev_reg <= GP_ZERO;
			fill_reg    <= 3'h0;
			ext_irq_o   <= '0;
			kr_irq_o    <= 1'b0;
			tb_count_o  <= 1'b0;
			sck_in_o    <= 1'b0;
			ssel_in_o   <= 1'b0;
			sin_o       <= 1'b0;
			cpt_o       <= 1'b0;
		end else begin
			gp_prev_reg <= gp_cur;
			fill_reg    <= {fill_reg[1:0], 1'b1};
			ext_irq_o   <= irq_next & {IRQ_N{fill_done}};
			kr_irq_o    <= kr_next & fill_done;
			tb_count_o  <= tb_next & fill_done;
			sck_in_o    <= gp_cur[BIT_SCK];
			ssel_in_o   <= gp_cur[BIT_SSEL];
			sin_o       <= gp_cur[BIT_SIN];
			cpt_o       <= gp_cur[BIT_CPT];
		end
	end

	// ==========================================================
	// Segment drivers and memory map decode
	logic [14:0] seg_mask;
	logic [15:0] disp_last;
	logic [15:0] rom_last;
	logic        rom_next;
	logic        disp_next;

	assign seg_mask  = SMALL_SEG ? SEG_MASK_SMALL : SEG_MASK_LARGE;
	assign disp_last = SMALL_SEG ? DISP_LAST_SMALL : DISP_LAST_LARGE;
	assign rom_last  = ROM_16K ? ROM_LAST_16K : ROM_LAST_12K;
	assign rom_next  = addr_i <= rom_last;
	assign disp_next = (addr_i >= DISP_RAM_BASE) && (addr_i <= disp_last);

	// Segments and commons stay driven, low while in reset
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			seg_o      <= 15'h0000;
			com_o      <= '0;
			rom_hit_o  <= 1'b0;
			disp_hit_o <= 1'b0;
		end else begin
			seg_o      <= seg_data_i & seg_mask;
			com_o      <= com_data_i;
			rom_hit_o  <= rom_next;
			disp_hit_o <= disp_next;
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	a_reset_all_input: assert property ($past(rst_i) |-> gp_oe_o == GP_ZERO)
		else $error("port drives a pin right after reset");
	a_p0_dir_bits: assert property (!rst_i |=>
		gp_oe_o[P0_LSB +: P0_W] == ~$past(gp_dir_i[P0_LSB +: P0_W]))
		else $error("port zero drive does not follow direction");
	a_p1_dir_bits: assert property (!rst_i |=>
		gp_oe_o[P1_LSB +: P1_W] == ~$past(gp_dir_i[P1_LSB +: P1_W]))
		else $error("port one drive does not follow direction");
	a_p7_dir_bits: assert property (!rst_i |=>
		gp_oe_o[P7_LSB +: P7_W] == ~$past(gp_dir_i[P7_LSB +: P7_W]))
		else $error("port seven drive does not follow direction");
	a_p89_presence: assert property (!rst_i |=> (gp_oe_o & P89_MASK)
		== ((SMALL_SEG ? ~$past(gp_dir_i) : GP_ZERO) & P89_MASK))
		else $error("port eight or nine drive wrong for this build");
	a_pu_input_only: assert property ((gp_pu_o & gp_oe_o) == GP_ZERO)
		else $error("pull-up on while the pin is driven");
	a_p5_pu_fixed: assert property (!$past(rst_i) |-> gp_pu_o[P5_LSB +: P5_W]
		== (P5_PULLUP & ~gp_oe_o[P5_LSB +: P5_W]))
		else $error("port five pull-up not from build option");
	a_p6_in_path: assert property (!$past(rst_i,1) && !$past(rst_i,2) && !$past(rst_i,3)
		|-> p6_rd_o == $past(p6_pin_i,3))
		else $error("input-only port read mismatch");
	a_irq_rise_only: assert property (ext_irq_o[0] && $past(irq_mode_i[1:0]) == 2'h1
		|-> $past(gp_pin_i[BIT_IRQ0],3) && !$past(gp_pin_i[BIT_IRQ0],4))
		else $error("rising-edge interrupt without a rising edge");
	a_irq_off_quiet: assert property ($past(irq_mode_i[1:0]) == 2'h0 |-> !ext_irq_o[0])
		else $error("disabled interrupt input fired");
	a_kr_falling: assert property (kr_irq_o |->
		|($past(kr_en_i) & ~$past(gp_pin_i[P0_LSB +: KR_N],3)))
		else $error("key event without a low enabled input");
	a_sck_master: assert property (ser_en_i && sck_master_i |=>
		gp_oe_o[BIT_SCK] && gp_pin_o[BIT_SCK] == $past(sck_out_i))
		else $error("master serial clock not driven");
	a_sck_slave: assert property (ser_en_i && !sck_master_i |=> !gp_oe_o[BIT_SCK])
		else $error("slave serial clock pin is driven");
	a_tb_count_edge: assert property (tb_count_o |->
		$past(gp_pin_i[BIT_TBIN],3) && !$past(gp_pin_i[BIT_TBIN],4))
		else $error("count pulse without rising edge");
	a_seg_unused: assert property (SMALL_SEG |-> seg_o[14:5] == 10'h000)
		else $error("unused segment driven on small build");
	a_disp_bound: assert property (disp_hit_o |-> $past(addr_i) <= disp_last)
		else $error("display hit beyond its last address");
	a_rom_bound: assert property (!$past(rst_i) |->
		rom_hit_o == ($past(addr_i) <= rom_last))
		else $error("program memory decode wrong");
	a_alt_buzzer: assert property (alt_en_i[0] && !gp_dir_i[BIT_BUZ] |=>
		gp_pin_o[BIT_BUZ] == $past(alt_val_i[0]))
		else $error("buzzer output not on its pin");

	c_irq_both: cover property ($past(irq_mode_i[1:0]) == 2'h3 && ext_irq_o[0]);
	c_key_event: cover property (kr_irq_o);
	c_sck_drive: cover property (gp_oe_o[BIT_SCK] && ser_en_i);
	c_tb_count: cover property (tb_count_o);

endmodule : ppm_port

// ### verilog/ppm_sync2.sv
// Two-flop synchroniser for a vector of pin levels.
// Assumes each bit is an independent level from outside the clock domain.
`timescale 1ns/1ns
module ppm_sync2 #(
	parameter int W = 8
) (
	input  wire logic         ref_clk_i, // System clock
	input  wire logic         rst_i,     // Synchronous reset, high
	input  wire logic [W-1:0] async_i,   // Raw pin levels
	output logic      [W-1:0] sync_o     // Synchronised levels
);

	logic [W-1:0] meta_reg;
	logic [W-1:0] sync_reg;

	// ==========================================================
	// First stage feeds the second stage only
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= async_i;
			sync_reg <= meta_reg;
		end
	end

	assign sync_o = sync_reg;

endmodule : ppm_sync2
